/* File: design/sdp_config_core.sv */
// serial configuration registers, divider fields and power-down precedence
`timescale 1ns/1ps
// Behaviour
// - a 24-bit word carries 20 data bits above a 4-bit select code (the main feedback word: 23 bits above a 0 in bit 0) and lands in the matching register.
// - the main reference ratio is the 6-bit field itself, one to 63, division by one allowed.
// - prescaler select 0 picks the 8/9/12/13 prescaler and 1 picks the 16/17/20/21 one.
// - main power-down bit 1 stops the main loop and floats its charge pump, 0 lets it run.
// - a low chip-enable pin powers the main loop down above every other control.
// - with chip enable high an auto power-up request runs the main loop whatever its bit says.
// - main count is modulus times C plus four times B plus A, all taken from the 11-bit field.
// - auxiliary power-down bit stops the auxiliary loop, and low chip enable forces that too.
module sdp_config_core
    import sdp_pkg::*;
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // serial configuration pins
    input wire logic serialClock,
    input wire logic serialData,
    input wire logic loadEnable,
    input wire logic chipEnable,
    // main loop settings
    output logic [10:0] mainFeedbackField,
    output logic [6:0] mainCCount,
    output logic [1:0] mainBCount,
    output logic [1:0] mainACount,
    output logic [11:0] mainFeedbackCount,
    output logic [11:0] mainFractionNumerator,
    output logic [11:0] mainFractionDenominator,
    output logic [5:0] mainReferenceDivider,
    output logic mainPrescalerSelect,
    output logic [4:0] mainPrescalerModulus,
    output logic mainLoopPowerDown,
    output logic autoPowerUp,
    output logic mainLoopActive,
    // auxiliary loop settings
    output logic [18:0] auxFeedbackField,
    output logic [14:0] auxBCount,
    output logic [3:0] auxACount,
    output logic auxLoopPowerDown,
    output logic auxLoopActive
);
    typedef struct packed {
        logic [WORD_BITS-1:0] shiftWord;
        logic clkPrev;
        logic loadPrev;
        logic [10:0] mainN;
        logic [11:0] fracNum;
        logic [11:0] fracDen;
        logic [5:0] refDiv;
        logic prescSel;
        logic mainPd;
        logic autoPu;
        logic [18:0] auxN;
        logic auxPd;
        logic [11:0] mainCount;
        logic mainActive;
        logic auxActive;
    } sdp_core_type;

    sdp_core_type state;
    sdp_core_type next_state;
    logic clkLevel;
    logic dataLevel;
    logic loadLevel;
    logic ceLevel;
    logic shiftStep;
    logic loadStep;
    logic [3:0] selCode;

    // lower prescaler modulus for the chosen prescaler
    function automatic logic [4:0] sdp_modulus(input logic sel);
        sdp_modulus = sel ? MAIN_MOD_HIGH : MAIN_MOD_LOW;
    endfunction : sdp_modulus

    // main feedback count from the packed C, B and A fields
    function automatic logic [11:0] sdp_main_count(input logic [10:0] n, input logic sel);
        logic [11:0] prod;
        // widen both factors first, a self-sized product would keep only 7 bits
        prod = 12'(sdp_modulus(sel)) * 12'(n[10:4]);
        sdp_main_count = prod + 12'({n[3:2], 2'b00}) + 12'(n[1:0]);
    endfunction : sdp_main_count

    // every pin crosses four flops (three stages plus the level flop) before use
    sdp_pin_filter u_clk_filter (.clk_sys(clk_sys), .rst(rst), .pinIn(serialClock),
        .level(clkLevel));
    sdp_pin_filter u_data_filter (.clk_sys(clk_sys), .rst(rst), .pinIn(serialData),
        .level(dataLevel));
    sdp_pin_filter u_load_filter (.clk_sys(clk_sys), .rst(rst), .pinIn(loadEnable),
        .level(loadLevel));
    sdp_pin_filter u_ce_filter (.clk_sys(clk_sys), .rst(rst), .pinIn(chipEnable),
        .level(ceLevel));

    // rising edges of the filtered serial clock and load strobe
    assign shiftStep = clkLevel & ~state.clkPrev;
    assign loadStep = loadLevel & ~state.loadPrev;
    assign selCode = state.shiftWord[SEL_MSB:0];

    // shift, decode on load, then settle derived counts and power state
    always_comb begin
        next_state = state;
        next_state.clkPrev = clkLevel;
        next_state.loadPrev = loadLevel;
        // msb first; host keeps data steady across its clock edge
        if (shiftStep) begin
            next_state.shiftWord = {state.shiftWord[WORD_BITS-2:0], dataLevel};
        end
        if (loadStep) begin
            // one-bit code goes first since it shares its low bit with all others
            if (state.shiftWord[MAIN_N_SEL_BIT] == 1'b0) begin
                next_state.mainN = state.shiftWord[MAIN_N_MSB:MAIN_N_LSB];
                next_state.fracNum = state.shiftWord[MAIN_FRAC_NUM_MSB:MAIN_FRAC_NUM_LSB];
                // auto power-up also wakes the auxiliary loop on this write
                if (state.autoPu) begin
                    next_state.auxPd = 1'b0;
                end
            end else if (selCode == SEL_MAIN_REF_POWER) begin
                next_state.mainPd = state.shiftWord[MAIN_PD_POS];
                next_state.prescSel = state.shiftWord[MAIN_PRESC_POS];
                next_state.refDiv = state.shiftWord[MAIN_REF_MSB:MAIN_REF_LSB];
                next_state.fracDen = state.shiftWord[MAIN_FRAC_DEN_MSB:MAIN_FRAC_DEN_LSB];
            end else if (selCode == SEL_AUX_FEEDBACK_POWER) begin
                next_state.auxPd = state.shiftWord[AUX_PD_POS];
                next_state.auxN = state.shiftWord[AUX_N_MSB:AUX_N_LSB];
            end else if (selCode == SEL_AUTO_POWER) begin
                next_state.autoPu = state.shiftWord[AUTO_PU_POS];
            end
            // other select codes belong to registers outside this block
        end
        next_state.mainCount = sdp_main_count(state.mainN, state.prescSel);
        // precedence: chip enable, then auto power-up, then the power-down bit
        next_state.mainActive = ceLevel & (state.autoPu | ~state.mainPd);
        next_state.auxActive = ceLevel & ~state.auxPd;
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            state <= '0;
            state.mainN <= RST_MAIN_N;
            state.refDiv <= RST_MAIN_REF;
            state.prescSel <= RST_MAIN_PRESC;
            state.mainPd <= RST_MAIN_PD;
            state.autoPu <= RST_AUTO_PU;
            state.auxN <= RST_AUX_N;
            state.auxPd <= RST_AUX_PD;
        end else begin
            state <= next_state;
        end
    end

    // outputs straight from the state flops, except the prescaler modulus, which is decoded from prescSel
    assign mainFeedbackField = state.mainN;
    assign mainCCount = state.mainN[10:4];
    assign mainBCount = state.mainN[3:2];
    assign mainACount = state.mainN[1:0];
    assign mainFeedbackCount = state.mainCount;
    assign mainFractionNumerator = state.fracNum;
    assign mainFractionDenominator = state.fracDen;
    assign mainReferenceDivider = state.refDiv;
    assign mainPrescalerSelect = state.prescSel;
    assign mainPrescalerModulus = sdp_modulus(state.prescSel);
    assign mainLoopPowerDown = state.mainPd;
    assign autoPowerUp = state.autoPu;
    assign mainLoopActive = state.mainActive; // low means charge pump floats
    assign auxFeedbackField = state.auxN;
    assign auxBCount = state.auxN[18:AUX_A_BITS];
    assign auxACount = state.auxN[AUX_A_BITS-1:0];
    assign auxLoopPowerDown = state.auxPd;
    assign auxLoopActive = state.auxActive;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    property p_main_ref_load;
        loadStep && state.shiftWord[0] && selCode == SEL_MAIN_REF_POWER
            |=> mainReferenceDivider == $past(state.shiftWord[21:16])
            && mainLoopPowerDown == $past(state.shiftWord[23]);
    endproperty
    a_main_ref_load: assert property (p_main_ref_load) else $error("ref word not stored");

    property p_foreign_code;
        loadStep && selCode != SEL_MAIN_REF_POWER |=> $stable(mainReferenceDivider);
    endproperty
    a_foreign_code: assert property (p_foreign_code) else $error("ref changed by other code");

    property p_ref_by_one;
        loadStep && selCode == SEL_MAIN_REF_POWER && state.shiftWord[21:16] == 6'h01
            |=> ##[0:3] mainReferenceDivider == 6'h01;
    endproperty
    a_ref_by_one: assert property (p_ref_by_one) else $error("divide by one refused");

    property p_modulus;
        mainPrescalerModulus == (mainPrescalerSelect ? 5'h10 : 5'h08);
    endproperty
    a_modulus: assert property (p_modulus) else $error("prescaler modulus wrong");

    property p_pd_bit;
        ceLevel && !autoPowerUp |=> mainLoopActive == !$past(mainLoopPowerDown);
    endproperty
    a_pd_bit: assert property (p_pd_bit) else $error("main power bit ignored");

    property p_ce_low;
        !ceLevel |=> !mainLoopActive && !auxLoopActive;
    endproperty
    a_ce_low: assert property (p_ce_low) else $error("chip enable low not obeyed");

    property p_auto_pu;
        ceLevel && autoPowerUp && mainLoopPowerDown |=> mainLoopActive;
    endproperty
    a_auto_pu: assert property (p_auto_pu) else $error("auto power-up ignored");

    property p_main_count;
        ##1 mainFeedbackCount == 12'($past(mainPrescalerModulus)) * 12'($past(mainCCount))
            + 12'({$past(mainBCount), 2'b00}) + 12'($past(mainACount));
    endproperty
    a_main_count: assert property (p_main_count) else $error("main count wrong");

    property p_aux_power;
        ##1 auxLoopActive == ($past(ceLevel) && !$past(auxLoopPowerDown));
    endproperty
    a_aux_power: assert property (p_aux_power) else $error("aux power state wrong");

    property p_aux_split;
        {auxBCount, auxACount} == auxFeedbackField;
    endproperty
    a_aux_split: assert property (p_aux_split) else $error("aux split wrong");
endmodule : sdp_config_core

/* File: design/sdp_pin_filter.sv */
// three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module sdp_pin_filter
    import sdp_pkg::*;
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // pin and filtered level
    input wire logic pinIn,
    output logic level
);
    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic level;
    } sdp_filter_type;

    sdp_filter_type state;
    sdp_filter_type next_state;

    // first stage feeds only the second; level moves once stages two and three agree
    always_comb begin
        next_state = state;
        next_state.s1 = pinIn;
        next_state.s2 = state.s1;
        next_state.s3 = state.s2;
        if (state.s2 == state.s3) begin
            next_state.level = state.s3;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign level = state.level;
endmodule : sdp_pin_filter

/* File: design/sdp_pkg.sv */
// constants shared by the synthesizer divider and power configuration block
package sdp_pkg;
    // serial word layout
    localparam int WORD_BITS = 24;
    localparam int SEL_MSB = 3;
    localparam int DATA_MSB = 23;
    localparam int DATA_LSB = 4;
    // register select codes in bits 3..0
    localparam logic [3:0] SEL_MAIN_REF_POWER = 4'h3;
    localparam logic [3:0] SEL_AUX_FEEDBACK_POWER = 4'h5;
    localparam logic [3:0] SEL_AUTO_POWER = 4'h9;
    // main feedback word: only bit 0 of the select code is checked
    localparam int MAIN_N_SEL_BIT = 0;
    localparam int MAIN_N_MSB = 23;
    localparam int MAIN_N_LSB = 13;
    localparam int MAIN_FRAC_NUM_MSB = 12;
    localparam int MAIN_FRAC_NUM_LSB = 1;
    // main reference / prescaler / power word
    localparam int MAIN_PD_POS = 23;
    localparam int MAIN_PRESC_POS = 22;
    localparam int MAIN_REF_MSB = 21;
    localparam int MAIN_REF_LSB = 16;
    localparam int MAIN_FRAC_DEN_MSB = 15;
    localparam int MAIN_FRAC_DEN_LSB = 4;
    // auxiliary feedback / power word
    localparam int AUX_PD_POS = 23;
    localparam int AUX_N_MSB = 22;
    localparam int AUX_N_LSB = 4;
    localparam int AUX_A_BITS = 4;
    // auto power-up word
    localparam int AUTO_PU_POS = 23;
    // main N sub-field split
    localparam int MAIN_C_BITS = 7;
    localparam int MAIN_B_BITS = 2;
    localparam int MAIN_A_BITS = 2;
    // prescaler lower moduli
    localparam logic [4:0] MAIN_MOD_LOW = 5'h08;
    localparam logic [4:0] MAIN_MOD_HIGH = 5'h10;
    // reset values
    localparam logic RST_MAIN_PD = 1'b1;
    localparam logic RST_AUX_PD = 1'b1;
    localparam logic RST_AUTO_PU = 1'b0;
    localparam logic RST_MAIN_PRESC = 1'b0;
    localparam logic [5:0] RST_MAIN_REF = 6'h01;
    localparam logic [10:0] RST_MAIN_N = 11'h000;
    localparam logic [18:0] RST_AUX_N = 19'h00000;
    // pin filter depth
    localparam int PIN_STAGES = 3;
endpackage : sdp_pkg

/* File: sim/sdp_host_model.sv */
// host controller model that shifts configuration words into the block
`timescale 1ns/1ps
module sdp_host_model (
    // clock
    input wire logic clk_sys,
    // serial pins
    output logic serialClock,
    output logic serialData,
    output logic loadEnable
);
    // pins idle low at time zero
    initial begin
        serialClock = 1'b0;
        serialData = 1'b0;
        loadEnable = 1'b0;
    end
    // 8-cycle phases stay above the 6-cycle filter margin
    task automatic hold8();
        repeat (8) @(negedge clk_sys);
    endtask : hold8
    // msb first, then a load strobe; callers keep every count legal
    task automatic send(input logic [23:0] w);
        for (int i = 23; i >= 0; i--) begin
            serialData = w[i];
            hold8();
            serialClock = 1'b1;
            hold8();
            serialClock = 1'b0;
        end
        hold8();
        loadEnable = 1'b1;
        hold8();
        loadEnable = 1'b0;
        serialData = ~serialData; // idle data must not mimic the last bit
        hold8();
    endtask : send
endmodule : sdp_host_model

/* File: sim/synth_divider_power_config_test.sv */
// self-checking bench for the divider and power configuration block
`timescale 1ns/1ps
module synth_divider_power_config_test;
    import sdp_pkg::*;
    logic clk_sys, rst, chipEnable, serialClock, serialData, loadEnable;
    logic [6:0] mainCCount;
    logic [1:0] mainBCount, mainACount;
    logic [11:0] mainFeedbackCount;
    logic [5:0] mainReferenceDivider;
    logic [4:0] mainPrescalerModulus;
    logic mainPrescalerSelect, mainLoopActive, auxLoopActive;
    logic [14:0] auxBCount;
    logic [3:0] auxACount;
    int n_mismatch = 0;
    int compares = 0;
    int cycles = 0;
    // clock and time-zero inputs
    initial begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end
    initial begin
        rst = 1'b1;
        chipEnable = 1'b1;
    end
    sdp_host_model host_u (.clk_sys(clk_sys), .serialClock(serialClock),
        .serialData(serialData), .loadEnable(loadEnable));
    sdp_config_core dut_u (.clk_sys(clk_sys), .rst(rst), .serialClock(serialClock),
        .serialData(serialData), .loadEnable(loadEnable), .chipEnable(chipEnable),
        .mainFeedbackField(), .mainCCount(mainCCount), .mainBCount(mainBCount),
        .mainACount(mainACount), .mainFeedbackCount(mainFeedbackCount),
        .mainFractionNumerator(), .mainFractionDenominator(),
        .mainReferenceDivider(mainReferenceDivider),
        .mainPrescalerSelect(mainPrescalerSelect),
        .mainPrescalerModulus(mainPrescalerModulus), .mainLoopPowerDown(),
        .autoPowerUp(), .mainLoopActive(mainLoopActive), .auxFeedbackField(),
        .auxBCount(auxBCount), .auxACount(auxACount), .auxLoopPowerDown(),
        .auxLoopActive(auxLoopActive));
    task automatic close_out();
        $display("mismatches %0d compares %0d", n_mismatch, compares);
        if (n_mismatch == 0 && compares > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : close_out
    // hang guard, eighteen words need about 7450 cycles
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            n_mismatch++;
            close_out();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        compares++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED at %0t: %s got %0h expected %0h", $time, what, got, exp);
        end
    endtask : chk
    // word plus settle time for the pin filters and the count stage
    task automatic put(input logic [23:0] w);
        host_u.send(w);
        repeat (4) @(negedge clk_sys);
    endtask : put
    task automatic t_reset();
        chk(mainLoopActive, 1'b0, "main off at reset");
        chk(auxLoopActive, 1'b0, "aux off at reset");
    endtask : t_reset
    task automatic t_main_reg();
        put({1'b0, 1'b1, 6'h01, 12'h5a5, SEL_MAIN_REF_POWER});
        chk(mainReferenceDivider, 6'h01, "divide by one");
        chk(mainPrescalerModulus, 5'h10, "high prescaler");
        chk(mainLoopActive, 1'b1, "main runs");
        put({1'b1, 1'b0, 6'h3f, 12'h000, SEL_MAIN_REF_POWER});
        chk(mainReferenceDivider, 6'h3f, "divide by 63");
        chk(mainPrescalerModulus, 5'h08, "low prescaler");
        chk(mainLoopActive, 1'b0, "main down");
    endtask : t_main_reg
    // table corners: fields 0x037 and 0x7f7 under both prescalers
    task automatic t_feedback();
        logic [10:0] fld[2] = '{11'h037, 11'h7f7};
        logic [11:0] lo[2] = '{12'd31, 12'd1023};
        logic [11:0] hi[2] = '{12'd55, 12'd2039};
        for (int p = 0; p < 2; p++) begin
            put({1'b0, p[0], 6'h01, 12'h000, SEL_MAIN_REF_POWER});
            for (int k = 0; k < 2; k++) begin
                put({fld[k], 12'h000, 1'b0});
                chk(mainCCount, {2'b00, fld[k][10:4]}, "c count");
                chk(mainBCount, fld[k][3:2], "b count");
                chk(mainFeedbackCount, (p == 0) ? lo[k] : hi[k], "main count");
            end
        end
    endtask : t_feedback
    task automatic t_aux();
        put({1'b0, 19'h00070, SEL_AUX_FEEDBACK_POWER});
        chk(auxBCount, 15'h0007, "aux b of 56");
        chk(auxACount, 4'h0, "aux a of 56");
        chk(auxLoopActive, 1'b1, "aux runs");
        put({1'b1, 19'h7fff7, SEL_AUX_FEEDBACK_POWER});
        chk(auxBCount, 15'h7fff, "aux b max");
        chk(auxACount, 4'h7, "aux a max");
        chk(auxLoopActive, 1'b0, "aux down");
    endtask : t_aux
    task automatic t_power();
        put({1'b0, 19'h00070, SEL_AUX_FEEDBACK_POWER});
        put({1'b1, 1'b0, 6'h01, 12'h000, SEL_MAIN_REF_POWER});
        put({1'b1, 19'h00000, SEL_AUTO_POWER});
        chk(mainLoopActive, 1'b1, "auto power-up wins over bit");
        chipEnable = 1'b0;
        repeat (8) @(negedge clk_sys);
        chk(mainLoopActive, 1'b0, "pin low beats auto");
        chk(auxLoopActive, 1'b0, "pin low stops aux");
        chipEnable = 1'b1;
        repeat (8) @(negedge clk_sys);
        chk(auxLoopActive, 1'b1, "aux back");
        chk(mainLoopActive, 1'b1, "auto again after pin");
        // a main feedback write under auto power-up must wake a parked aux loop
        put({1'b1, 19'h00070, SEL_AUX_FEEDBACK_POWER});
        chk(auxLoopActive, 1'b0, "aux parked");
        put({11'h037, 12'h000, 1'b0});
        chk(auxLoopActive, 1'b1, "main write wakes aux");
        put({1'b0, 19'h00000, SEL_AUTO_POWER});
        chk(mainLoopActive, 1'b0, "bit governs again");
    endtask : t_power
    // odd codes that select nothing must leave the settings alone
    task automatic t_unmapped();
        logic [3:0] sel[2] = '{4'hb, 4'h7};
        for (int k = 0; k < 2; k++) begin
            put({1'b0, 1'b1, 6'h2a, 12'h000, sel[k]});
            chk(mainReferenceDivider, 6'h01, "divider kept");
            chk(mainPrescalerSelect, 1'b0, "prescaler kept");
        end
    endtask : t_unmapped
    // main sequence
    initial begin
        repeat (16) @(negedge clk_sys);
        rst = 1'b0;
        @(negedge clk_sys);
        t_reset();
        t_main_reg();
        t_feedback();
        t_aux();
        t_power();
        t_unmapped();
        close_out();
    end
endmodule : synth_divider_power_config_test
